/* File: hw/rep_pkg.sv */
// Constants and types for the ROM emulation memory port
// How it works
// - Latch read byte before data strobe rises
// - Drive address during first machine state
// - Output every address, internal or external
// - Address strobe low every first state
// - Address strobe always driven, never floated
// - Data strobe only inside emulated ROM
// - Export system clock on output pin
// - Sync marks last instruction cycle
// - Acknowledge low during interrupt cycle
// - Low four selects active low, top high
// - Decode select code into ROM size
// - Selects can mimic ROM-less strobe behaviour
// - Ports 0 and 1 inputs after reset
// - Selects set internal/external boundary
`default_nettype none
package rep_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int REP_AW = 16;
  localparam int REP_DW = 8;
  localparam int REP_SW = 5;
  // ---------------------------------------------------------------
  // Size-select codes, read {top, bit3, bit2, bit1, bit0}
  // ---------------------------------------------------------------
  localparam logic [4:0] REP_SEL_NONE = 5'h0f;
  localparam logic [4:0] REP_SEL_2K = 5'h0e;
  localparam logic [4:0] REP_SEL_4K = 5'h0d;
  localparam logic [4:0] REP_SEL_8K = 5'h0b;
  localparam logic [4:0] REP_SEL_16K = 5'h07;
  localparam logic [4:0] REP_SEL_32K = 5'h1f;
  // ---------------------------------------------------------------
  // ROM limits (first external address)
  // ---------------------------------------------------------------
  localparam logic [16:0] REP_LIM_NONE = 17'h00000;
  localparam logic [16:0] REP_LIM_2K = 17'h00800;
  localparam logic [16:0] REP_LIM_4K = 17'h01000;
  localparam logic [16:0] REP_LIM_8K = 17'h02000;
  localparam logic [16:0] REP_LIM_16K = 17'h04000;
  localparam logic [16:0] REP_LIM_32K = 17'h08000;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] REP_RST_ADDR = 16'h0000;
  localparam logic [7:0] REP_RST_DATA = 8'h00;
  localparam logic [7:0] REP_PORT_DIR_IN = 8'h00;
  // Machine cycle phases
  typedef enum logic [3:0] {
    REP_IDLE = 4'b0001,
    REP_T1 = 4'b0010,
    REP_T2 = 4'b0100,
    REP_T3 = 4'b1000
  } rep_phase_e;
endpackage : rep_pkg
`default_nettype wire

/* File: hw/rep_span_decode.sv */
// Size-select synchroniser and ROM boundary decoder
`default_nettype none
module rep_span_decode
  import rep_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw select pins
  input wire logic [REP_SW-1:0] sel_raw,
  // Decoded limit
  output logic [16:0] rom_limit
);
  import rep_pkg::*;

  typedef struct packed {
    logic [REP_SW-1:0] s1;
    logic [REP_SW-1:0] s2;
    logic [16:0] lim;
  } rep_dec_s;

  rep_dec_s st_q;
  rep_dec_s st_d;

  // Code to limit; unknown codes give no ROM
  function automatic logic [16:0] rep_limit(input logic [4:0] c);
    case (c)
      REP_SEL_2K: rep_limit = REP_LIM_2K;
      REP_SEL_4K: rep_limit = REP_LIM_4K;
      REP_SEL_8K: rep_limit = REP_LIM_8K;
      REP_SEL_16K: rep_limit = REP_LIM_16K;
      REP_SEL_32K: rep_limit = REP_LIM_32K;
      default: rep_limit = REP_LIM_NONE;
    endcase
  endfunction : rep_limit

  // Two-stage sync then decode
  always_comb begin
    st_d = st_q;
    st_d.s1 = sel_raw;
    st_d.s2 = st_q.s1;
    st_d.lim = rep_limit(st_q.s2);
  end

  // State register; limit held none in reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rom_limit = st_q.lim;
endmodule : rep_span_decode
`default_nettype wire

/* File: hw/rep_emu_port.sv */
// ROM emulation memory port top level
`default_nettype none
module rep_emu_port
  import rep_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // Core side
  input wire logic CORE_CYC_START,
  input wire logic [REP_AW-1:0] CORE_ADDR,
  input wire logic CORE_INSTR_LAST,
  input wire logic CORE_IRQ_CYCLE,
  input wire logic CORE_EXT_BUS_FLOAT,
  output logic [REP_DW-1:0] CORE_FETCH_DATA,
  output logic CORE_FETCH_VALID,
  output logic CORE_ADDR_INTERNAL,
  // Emulation memory pins
  input wire logic [REP_DW-1:0] EMU_READ_DATA_IN,
  output logic [REP_AW-1:0] EMU_ADDRESS_OUT,
  output logic MEM_ADDR_STROBE_N,
  output logic MEM_DATA_STROBE_N,
  // Status pins
  output logic SCLK_OUT,
  output logic SYNC_OUT_N,
  output logic IRQ_ACK_CYCLE_N,
  // Size-select pins
  input wire logic ROM_SPAN_SEL_N_BIT0,
  input wire logic ROM_SPAN_SEL_N_BIT1,
  input wire logic ROM_SPAN_SEL_N_BIT2,
  input wire logic ROM_SPAN_SEL_N_BIT3,
  input wire logic ROM_SPAN_SEL_TOP,
  // Port 0 and 1 direction (1 = output)
  output logic [7:0] PORT0_DIR_OUT,
  output logic [7:0] PORT1_DIR_OUT,
  input wire logic PORT_DIR_WE,
  input wire logic [7:0] PORT0_DIR_IN,
  input wire logic [7:0] PORT1_DIR_IN
);
  import rep_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rep_phase_e ph;
    logic [REP_AW-1:0] addr;
    logic internal;
    logic mas_n;
    logic mds_n;
    logic [REP_DW-1:0] d1;
    logic [REP_DW-1:0] d2;
    logic [REP_DW-1:0] fetch;
    logic fvalid;
    logic [1:0] pend;
    logic sync_n;
    logic ack_n;
    logic [7:0] p0dir;
    logic [7:0] p1dir;
  } rep_st_s;

  rep_st_s st_q;
  rep_st_s st_d;
  logic [16:0] rom_limit;

  // Boundary decoder
  rep_span_decode u_dec (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .sel_raw({ROM_SPAN_SEL_TOP, ROM_SPAN_SEL_N_BIT3, ROM_SPAN_SEL_N_BIT2,
              ROM_SPAN_SEL_N_BIT1, ROM_SPAN_SEL_N_BIT0}),
    .rom_limit(rom_limit)
  );

  // Is an address inside the emulated ROM
  function automatic logic rep_inside(input logic [15:0] a,
                                      input logic [16:0] lim);
    rep_inside = ({1'b0, a} < lim);
  endfunction : rep_inside

  // Machine cycle sequencer and pin values
  always_comb begin
    st_d = st_q;
    st_d.fvalid = 1'b0;
    // Read byte is taken once the last strobe-low sample leaves the sync
    st_d.pend = {st_q.pend[0], 1'b0};
    if (st_q.pend[1]) begin
      st_d.fetch = st_q.d2;
      st_d.fvalid = 1'b1;
    end
    st_d.d1 = EMU_READ_DATA_IN;
    st_d.d2 = st_q.d1;
    st_d.sync_n = ~CORE_INSTR_LAST;
    st_d.ack_n = ~CORE_IRQ_CYCLE;
    if (PORT_DIR_WE) begin
      st_d.p0dir = PORT0_DIR_IN;
      st_d.p1dir = PORT1_DIR_IN;
    end
    case (st_q.ph)
      REP_IDLE: begin
        st_d.mas_n = 1'b1;
        st_d.mds_n = 1'b1;
        if (CORE_CYC_START) begin
          st_d.ph = REP_T1;
          st_d.addr = CORE_ADDR;
          st_d.internal = rep_inside(CORE_ADDR, rom_limit);
          st_d.mas_n = 1'b0;
        end
      end
      REP_T1: begin
        st_d.ph = REP_T2;
        st_d.mas_n = 1'b1;
        st_d.mds_n = ~st_q.internal;
      end
      REP_T2: begin
        st_d.ph = REP_T3;
      end
      REP_T3: begin
        st_d.ph = REP_IDLE;
        st_d.mds_n = 1'b1;
        st_d.pend[0] = st_q.internal;
      end
      default: st_d.ph = REP_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      st_q.ph <= REP_IDLE;
      st_q.addr <= REP_RST_ADDR;
      st_q.internal <= 1'b0;
      st_q.mas_n <= 1'b1;
      st_q.mds_n <= 1'b1;
      st_q.d1 <= REP_RST_DATA;
      st_q.d2 <= REP_RST_DATA;
      st_q.fetch <= REP_RST_DATA;
      st_q.fvalid <= 1'b0;
      st_q.pend <= 2'b00;
      st_q.sync_n <= 1'b1;
      st_q.ack_n <= 1'b1;
      st_q.p0dir <= REP_PORT_DIR_IN;
      st_q.p1dir <= REP_PORT_DIR_IN;
    end else begin
      st_q <= st_d;
    end
  end

  // Pins; strobe is never floated, bus float input unused here
  assign EMU_ADDRESS_OUT = st_q.addr;
  assign MEM_ADDR_STROBE_N = st_q.mas_n;
  assign MEM_DATA_STROBE_N = st_q.mds_n;
  assign SCLK_OUT = SYS_CLK;
  assign SYNC_OUT_N = st_q.sync_n;
  assign IRQ_ACK_CYCLE_N = st_q.ack_n;
  assign CORE_FETCH_DATA = st_q.fetch;
  assign CORE_FETCH_VALID = st_q.fvalid;
  assign CORE_ADDR_INTERNAL = st_q.internal;
  assign PORT0_DIR_OUT = st_q.p0dir;
  assign PORT1_DIR_OUT = st_q.p1dir;

  // ---------------------------------------------------------------
  // Checks: address phase
  // ---------------------------------------------------------------
  // Start of a machine cycle as the sequencer accepts it
  logic cyc_take;
  assign cyc_take = (st_q.ph == REP_IDLE) && CORE_CYC_START;

  // Accepted start
  sequence s_start;
    cyc_take;
  endsequence
  // Address strobe low for one state, then high again
  sequence s_t1;
    !MEM_ADDR_STROBE_N ##1 MEM_ADDR_STROBE_N;
  endsequence
  // Accepted start whose address lies outside the emulated ROM
  sequence s_ext_cycle;
    cyc_take ##1 !CORE_ADDR_INTERNAL;
  endsequence
  // Accepted start whose address lies inside the emulated ROM
  sequence s_int_cycle;
    cyc_take ##1 CORE_ADDR_INTERNAL;
  endsequence
  // Data strobe low for two states, then high again
  sequence s_mds_pulse;
    !MEM_DATA_STROBE_N [*2] ##1 MEM_DATA_STROBE_N;
  endsequence

  // Address strobe pulses in the first state of every cycle
  chk_mas_first_state: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    s_start |=> s_t1)
    else $error("address strobe not pulsed");

  // Address of the accepted start is on the pins in the first state
  chk_addr_driven: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    s_start |=> EMU_ADDRESS_OUT == $past(CORE_ADDR))
    else $error("address not driven");

  // Address only moves when a new cycle is accepted
  chk_addr_stands: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    !cyc_take |=> $stable(EMU_ADDRESS_OUT))
    else $error("address moved outside a start");

  // A floated external bus does not take the address strobe with it
  chk_mas_float: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (CORE_EXT_BUS_FLOAT and s_start) |=> !MEM_ADDR_STROBE_N)
    else $error("strobe lost under float");

  // Address strobe is low only right after an accepted start
  chk_mas_only_t1: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    !MEM_ADDR_STROBE_N |-> $past(cyc_take))
    else $error("address strobe outside first state");

  // A start while busy is dropped without touching the pins
  chk_busy_refused: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (CORE_CYC_START && st_q.ph != REP_IDLE)
    |=> MEM_ADDR_STROBE_N && $stable(EMU_ADDRESS_OUT))
    else $error("busy start not refused");

  // ---------------------------------------------------------------
  // Checks: data phase
  // ---------------------------------------------------------------
  // Data strobe never leaves the emulated ROM range
  chk_mds_range: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    !MEM_DATA_STROBE_N |-> CORE_ADDR_INTERNAL)
    else $error("data strobe outside ROM");

  // Data strobe is two states wide
  chk_mds_width: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    $fell(MEM_DATA_STROBE_N) |-> s_mds_pulse)
    else $error("data strobe width");

  // Every internal cycle gets its data strobe
  chk_mds_internal: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    s_int_cycle |=> s_mds_pulse)
    else $error("data strobe missing inside ROM");

  // External cycles leave the data strobe idle
  chk_mds_external: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    s_ext_cycle |=> MEM_DATA_STROBE_N [*3])
    else $error("data strobe on external cycle");

  // Byte handed over is the pin value of the last strobe-low state
  chk_fetch_data: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    $rose(MEM_DATA_STROBE_N) |-> ##2 (CORE_FETCH_VALID
    && CORE_FETCH_DATA == $past(EMU_READ_DATA_IN, 3)))
    else $error("fetch data wrong");

  // Fetch valid is a single-cycle pulse
  chk_fetch_pulse: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    CORE_FETCH_VALID |=> !CORE_FETCH_VALID)
    else $error("fetch valid too long");

  // Fetch valid only follows a strobed read
  chk_fetch_source: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    CORE_FETCH_VALID |-> !$past(MEM_DATA_STROBE_N, 3))
    else $error("fetch without data strobe");

  // ---------------------------------------------------------------
  // Checks: status pins
  // ---------------------------------------------------------------
  // Sync goes low after the last cycle of an instruction
  chk_sync_last: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    CORE_INSTR_LAST |=> !SYNC_OUT_N)
    else $error("sync missing");

  // Sync stays high in every other cycle
  chk_sync_idle: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    !CORE_INSTR_LAST |=> SYNC_OUT_N)
    else $error("sync outside last cycle");

  // Acknowledge follows a change of the interrupt cycle
  chk_ack_low: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    CORE_IRQ_CYCLE != $past(CORE_IRQ_CYCLE) |=> IRQ_ACK_CYCLE_N
    == !$past(CORE_IRQ_CYCLE))
    else $error("ack level wrong");

  // Acknowledge never moves on its own
  chk_ack_follows: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    $changed(IRQ_ACK_CYCLE_N) |-> IRQ_ACK_CYCLE_N == !$past(CORE_IRQ_CYCLE))
    else $error("ack changed without cause");

  // ---------------------------------------------------------------
  // Checks: port direction
  // ---------------------------------------------------------------
  // Reset leaves ports 0 and 1 as inputs
  chk_ports_reset: assert property (
    @(posedge SYS_CLK)
    !NRST |=> PORT0_DIR_OUT == 8'h00 && PORT1_DIR_OUT == 8'h00)
    else $error("ports not inputs");

  // Direction load takes both bytes in one cycle
  chk_dir_load: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    PORT_DIR_WE |=> PORT0_DIR_OUT == $past(PORT0_DIR_IN)
    && PORT1_DIR_OUT == $past(PORT1_DIR_IN))
    else $error("direction load lost");
endmodule : rep_emu_port
`default_nettype wire

/* File: verification/rep_emu_mem.sv */
// Model of the external memory that stands in for the program ROM
`default_nettype none
module rep_emu_mem
  import rep_pkg::*;
(
  // Pins from the port
  input wire logic [REP_AW-1:0] address,
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  // Read byte back to the port
  output logic [REP_DW-1:0] read_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [REP_AW-1:0] addr_q = 16'h0000;
  logic [REP_DW-1:0] last_q = 8'h00;
  logic [REP_DW-1:0] byte_w;
  // Address is latched on the rising edge of the address strobe
  always @(posedge addr_strobe_n) addr_q <= address;
  // Stored byte is a fixed function of the address
  assign byte_w = addr_q[7:0] ^ addr_q[15:8] ^ 8'h5a;
  // Released lines show the inverse of the last byte, never a stale match
  always @(posedge data_strobe_n) last_q <= byte_w;
  assign read_data = !data_strobe_n ? byte_w : ~last_q;
endmodule : rep_emu_mem
`default_nettype wire

/* File: verification/rep_emu_port_tb.sv */
// Self-checking testbench for the ROM emulation memory port
`default_nettype none
module rep_emu_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rep_pkg::*;
  logic clk = 0, nrst = 0, start = 0, last = 0, irq = 0, flt = 0, we = 0;
  logic [15:0] addr = 16'h0000;
  logic [4:0] sel = 5'h0f;
  logic [7:0] pi0 = 8'h00, pi1 = 8'h00, rd, fd, p0, p1;
  logic [15:0] ea;
  logic fv, ai, mas, mds, sclk, syn, ack;
  int failures = 0, checks = 0, cycles = 0;
  // ---------------------------------------------------------------
  // Clock, design and memory model
  // ---------------------------------------------------------------
  always #12.5 clk = ~clk;
  rep_emu_port i_dut (.SYS_CLK(clk), .NRST(nrst), .CORE_CYC_START(start),
    .CORE_ADDR(addr), .CORE_INSTR_LAST(last), .CORE_IRQ_CYCLE(irq),
    .CORE_EXT_BUS_FLOAT(flt), .CORE_FETCH_DATA(fd), .CORE_FETCH_VALID(fv),
    .CORE_ADDR_INTERNAL(ai), .EMU_READ_DATA_IN(rd), .EMU_ADDRESS_OUT(ea),
    .MEM_ADDR_STROBE_N(mas), .MEM_DATA_STROBE_N(mds), .SCLK_OUT(sclk),
    .SYNC_OUT_N(syn), .IRQ_ACK_CYCLE_N(ack), .ROM_SPAN_SEL_N_BIT0(sel[0]),
    .ROM_SPAN_SEL_N_BIT1(sel[1]), .ROM_SPAN_SEL_N_BIT2(sel[2]),
    .ROM_SPAN_SEL_N_BIT3(sel[3]), .ROM_SPAN_SEL_TOP(sel[4]),
    .PORT0_DIR_OUT(p0), .PORT1_DIR_OUT(p1), .PORT_DIR_WE(we),
    .PORT0_DIR_IN(pi0), .PORT1_DIR_IN(pi1));
  rep_emu_mem i_mem (.address(ea), .addr_strobe_n(mas),
    .data_strobe_n(mds), .read_data(rd));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Selects only change while reset is held
  task automatic do_reset(input logic [4:0] code);
    @(negedge clk);
    nrst = 0;
    sel = code;
    repeat (10) @(negedge clk);
    nrst = 1;
    repeat (4) @(negedge clk);
  endtask : do_reset
  // One machine cycle, checked state by state
  task automatic fetch(input logic [15:0] a, input logic in);
    logic [7:0] b;
    b = a[7:0] ^ a[15:8] ^ 8'h5a;
    start = 1;
    addr = a;
    flt = a[0];
    // First state: address and strobe are out
    @(negedge clk);
    start = 0;
    chk(ea, a);
    chk(mas, 0);
    chk(ai, in);
    @(negedge clk);
    chk(mas, 1);
    chk(mds, !in);
    // A start while busy must be ignored
    start = 1;
    addr = ~a;
    @(negedge clk);
    start = 0;
    addr = a;
    chk(mds, !in);
    chk(ea, a);
    chk(mas, 1);
    @(negedge clk);
    chk(mds, 1);
    @(negedge clk);
    chk(fv, 0);
    // Byte arrives once the last strobe-low sample is through the sync
    @(negedge clk);
    chk(fv, in);
    if (in) chk(fd, b);
  endtask : fetch
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset state, direction load, and reset again
  task automatic port_dirs;
    chk({mas, mds, syn, ack}, 4'hf);
    chk({p1, p0}, 16'h0000);
    we = 1;
    pi0 = 8'ha5;
    pi1 = 8'h3c;
    @(negedge clk);
    we = 0;
    chk({p1, p0}, 16'h3ca5);
    do_reset(5'h0f);
    chk({p1, p0}, 16'h0000);
  endtask : port_dirs
  // Clock export, sync and interrupt acknowledge
  task automatic status;
    @(posedge clk);
    #1;
    chk(sclk, 1);
    @(negedge clk);
    #1;
    chk(sclk, 0);
    @(negedge clk);
    last = 1;
    @(negedge clk);
    last = 0;
    chk(syn, 0);
    @(negedge clk);
    chk(syn, 1);
    irq = 1;
    repeat (2) @(negedge clk);
    chk(ack, 0);
    irq = 0;
    @(negedge clk);
    chk(ack, 1);
  endtask : status
  // Each named select code plus the unknown code 5'h00, inside (when a ROM is selected) and outside each boundary
  task automatic size_map;
    logic [4:0] c [7] = '{5'h0f, 5'h0e, 5'h0d, 5'h0b, 5'h07, 5'h1f, 5'h00};
    logic [15:0] l [7] = '{16'h0000, 16'h0800, 16'h1000, 16'h2000,
      16'h4000, 16'h8000, 16'h0000};
    for (int i = 0; i < 7; i++) begin
      do_reset(c[i]);
      if (l[i] != 16'h0000) fetch(l[i] - 16'h0001, 1);
      fetch(l[i], 0);
      fetch(16'hffff, 0);
    end
  endtask : size_map
  // Verdict and end of run
  task automatic complete_run;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run;
    end
  end
  // Main sequence
  initial begin
    do_reset(5'h0e);
    port_dirs;
    status;
    size_map;
    complete_run;
  end
endmodule : rep_emu_port_tb
`default_nettype wire
